// ===== gpiopg_pkg.sv
// Package: register map, field positions and reset values of the GPIO unit
package gpiopg_pkg;
   // Block bases
   localparam logic [31:0] PINT_BASE = 32'h4004c000;
   localparam logic [31:0] GRP0_BASE = 32'h4005c000;
   localparam logic [31:0] GRP1_BASE = 32'h40060000;
   localparam logic [31:0] PORT_BASE = 32'h50000000;
   localparam logic [31:0] BLK_MASK = 32'hfffff000;
   // Pin interrupt block offsets
   localparam logic [11:0] PINT_MODE = 12'h000;
   localparam logic [11:0] PINT_ENR = 12'h004;
   localparam logic [11:0] PINT_ENF = 12'h010;
   localparam logic [11:0] PINT_RISE = 12'h01c;
   localparam logic [11:0] PINT_FALL = 12'h020;
   localparam logic [11:0] PINT_STAT = 12'h024;
   localparam logic [11:0] PINT_SEL0 = 12'h040;
   // Group block offsets
   localparam logic [11:0] GRP_CTRL = 12'h000;
   localparam logic [11:0] GRP_POL0 = 12'h020;
   localparam logic [11:0] GRP_POL1 = 12'h024;
   localparam logic [11:0] GRP_ENA0 = 12'h040;
   localparam logic [11:0] GRP_ENA1 = 12'h044;
   // Port block offsets
   localparam logic [11:0] PORT_DIR0 = 12'h000;
   localparam logic [11:0] PORT_DIR1 = 12'h004;
   localparam logic [11:0] PORT_VAL0 = 12'h100;
   localparam logic [11:0] PORT_VAL1 = 12'h104;
   localparam logic [11:0] PORT_PIN0 = 12'h200;
   localparam logic [11:0] PORT_PIN_LAST = 12'h2fc;
   // Group control fields
   localparam int GRP_STAT_BIT = 0;
   localparam int GRP_COMB_BIT = 1;
   localparam int GRP_TRIG_BIT = 2;
   // Sizes and reset values
   localparam int NPINT = 8;
   localparam int NPIN = 64;
   localparam logic [31:0] RST_ZERO = 32'h00000000;
   localparam logic [31:0] RSV_READ = 32'h00000000;
   localparam logic [5:0] SEL_RST = 6'h00;
endpackage

// ===== gpiopg_grp.sv
// Module: one grouped-interrupt block over ports 0 and 1
`timescale 1ns/1ps
module gpiopg_grp
   import gpiopg_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [NPIN-1:0] pins,
   input wire logic sel,
   input wire logic wr,
   input wire logic [11:0] addr,
   input wire logic [31:0] wdata,
   input wire logic sleeping,
   output logic [31:0] rdata,
   output logic irq_ff,
   output logic wake_ff
);
   logic [NPIN-1:0] pol_ff;
   logic [NPIN-1:0] ena_ff;
   logic comb_ff;
   logic trig_ff;
   logic stat_ff;
   logic hit_ff;
   logic [NPIN-1:0] act;
   logic hit;
   // ---------------------------------------------------------------
   // Configuration
   // ---------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         pol_ff <= '0;
         ena_ff <= '0;
         comb_ff <= 1'b0;
         trig_ff <= 1'b0;
      end
      else if (sel && wr)
      begin
         if (addr == GRP_CTRL)
         begin
            comb_ff <= wdata[GRP_COMB_BIT];
            trig_ff <= wdata[GRP_TRIG_BIT];
         end
         if (addr == GRP_POL0) pol_ff[31:0] <= wdata;
         if (addr == GRP_POL1) pol_ff[63:32] <= wdata;
         if (addr == GRP_ENA0) ena_ff[31:0] <= wdata;
         if (addr == GRP_ENA1) ena_ff[63:32] <= wdata;
      end
   end
   // ---------------------------------------------------------------
   // Pattern detection
   // ---------------------------------------------------------------
   // Disabled inputs are forced neutral so AND mode ignores them
   // Polarity bit set means the input is active high
   assign act = ~(pins ^ pol_ff);
   always_comb
   begin
      if (ena_ff == '0)
         hit = 1'b0;
      else if (comb_ff)
         hit = &(act | ~ena_ff);
      else
         hit = |(act & ena_ff);
   end
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         hit_ff <= 1'b0;
      else
         hit_ff <= hit;
   end
   // Status: set wins over a clear in the same cycle
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         stat_ff <= 1'b0;
      else if (trig_ff ? (hit && !hit_ff) : hit)
         stat_ff <= 1'b1;
      else if (sel && wr && addr == GRP_CTRL && wdata[GRP_STAT_BIT])
         stat_ff <= 1'b0;
   end
   // Wake is raised on the raw match, one cycle ahead of the request
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         wake_ff <= 1'b0;
      else
         wake_ff <= sleeping && hit;
   end
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         irq_ff <= 1'b0;
      else
         irq_ff <= stat_ff;
   end
   always_comb
   begin
      rdata = RSV_READ;
      unique case (addr)
         GRP_CTRL: rdata = {29'h0, trig_ff, comb_ff, stat_ff};
         GRP_POL0: rdata = pol_ff[31:0];
         GRP_POL1: rdata = pol_ff[63:32];
         GRP_ENA0: rdata = ena_ff[31:0];
         GRP_ENA1: rdata = ena_ff[63:32];
         default: rdata = RSV_READ;
      endcase
   end
endmodule // gpiopg_grp

// ===== gpiopg_top.sv
// Module: GPIO port, pin interrupts and two grouped interrupts
// Operation
// - Up to eight pins, each chosen from any GPIO pin, feed pin interrupts.
// - Each pin interrupt has its own request output line.
// - Edge mode fires on rising, falling, or both edges.
// - Level mode asserts while pin sits at its chosen level.
// - Any number of pins may be enabled into a group.
// - Each group input has its own high or low polarity.
// - Group combines enabled inputs by OR or AND.
// - Two independent group blocks, each with own configuration.
// - Group output is level or edge triggered.
// - A group match can wake the part from power saving.
// - In power saving, wake-up comes before the interrupt request.
// - Writing one to the group status bit clears its request.
// - Each pin is software-set as input or output.
// - After reset all pins are inputs, all interrupts disabled.
// - Per-pin registers read or set one pin alone.
// - Port reads give input levels and drive written outputs.
// - Registers map 32 pins per port, one bit per pin.
// - Undefined bits ignore writes and read as zero.
// - Pin interrupt block decodes at its own base.
// - The two group blocks sit at two separate bases.
// - Port block decodes at its own base.
// - Groups take any pin on ports 0 and 1.
`timescale 1ns/1ps
module gpiopg_top
   import gpiopg_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rdata_ff,
   input wire logic [NPIN-1:0] pin_in,
   output logic [NPIN-1:0] pin_out_ff,
   output logic [NPIN-1:0] pin_oe_ff,
   input wire logic sleeping,
   output logic [NPINT-1:0] pin_irq_ff,
   output logic [1:0] group_irq_ff,
   output logic [1:0] group_wake_ff
);
   logic [NPIN-1:0] dir_ff;
   logic [NPIN-1:0] val_ff;
   logic [NPIN-1:0] sync1_ff;
   logic [NPIN-1:0] sync2_ff;
   logic [NPINT-1:0] mode_ff;
   logic [NPINT-1:0] enr_ff;
   logic [NPINT-1:0] enf_ff;
   logic [NPINT-1:0] rise_ff;
   logic [NPINT-1:0] fall_ff;
   logic [NPINT-1:0] src_ff;
   logic [NPINT-1:0] src_prev_ff;
   logic [5:0] sel_ff [NPINT];
   logic [NPINT-1:0] src;
   logic [NPINT-1:0] irq_nxt;
   logic sel_pint;
   logic sel_g0;
   logic sel_g1;
   logic sel_port;
   logic [11:0] off;
   logic [31:0] g0_rdata;
   logic [31:0] g1_rdata;
   logic [31:0] nxt_rdata;
   logic [NPIN-1:0] pin_view;
   logic wr_dir0;
   logic wr_dir1;
   logic wr_val0;
   logic wr_val1;
   logic wr_pin;
   logic wr_mode;
   logic wr_enr;
   logic wr_enf;
   logic wr_rise;
   logic wr_fall;
   logic wr_sel;
   logic [NPINT-1:0] rise_clr;
   logic [NPINT-1:0] fall_clr;

   // Address decode helper, reused for every block
   function automatic logic blk_hit(input logic [31:0] a, input logic [31:0] base);
      blk_hit = (a & BLK_MASK) == base;
   endfunction

   // Register write strobe for one offset of one block
   function automatic logic reg_wr(input logic en, input logic blk, input logic [11:0] o,
      input logic [11:0] target);
      reg_wr = en && blk && (o == target);
   endfunction

   // Per-pin window: one word per pin, bit 0 carries the level
   function automatic logic pin_win(input logic [11:0] o);
      pin_win = (o >= PORT_PIN0) && (o <= PORT_PIN_LAST);
   endfunction

   // Source select window: eight words, index taken from the word address
   function automatic logic sel_win(input logic [11:0] o);
      sel_win = o[11:5] == PINT_SEL0[11:5];
   endfunction

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   assign off = addr[11:0];
   assign sel_pint = blk_hit(addr, PINT_BASE);
   assign sel_g0 = blk_hit(addr, GRP0_BASE);
   assign sel_g1 = blk_hit(addr, GRP1_BASE);
   assign sel_port = blk_hit(addr, PORT_BASE);

   // ---------------------------------------------------------------
   // Write strobes
   // ---------------------------------------------------------------
   assign wr_dir0 = reg_wr(wr_en, sel_port, off, PORT_DIR0);
   assign wr_dir1 = reg_wr(wr_en, sel_port, off, PORT_DIR1);
   assign wr_val0 = reg_wr(wr_en, sel_port, off, PORT_VAL0);
   assign wr_val1 = reg_wr(wr_en, sel_port, off, PORT_VAL1);
   assign wr_pin = wr_en && sel_port && pin_win(off);
   assign wr_mode = reg_wr(wr_en, sel_pint, off, PINT_MODE);
   assign wr_enr = reg_wr(wr_en, sel_pint, off, PINT_ENR);
   assign wr_enf = reg_wr(wr_en, sel_pint, off, PINT_ENF);
   assign wr_rise = reg_wr(wr_en, sel_pint, off, PINT_RISE);
   assign wr_fall = reg_wr(wr_en, sel_pint, off, PINT_FALL);
   assign wr_sel = wr_en && sel_pint && sel_win(off);
   // Write-one-to-clear masks for the edge flags
   assign rise_clr = wr_rise ? wdata[NPINT-1:0] : '0;
   assign fall_clr = wr_fall ? wdata[NPINT-1:0] : '0;

   // ---------------------------------------------------------------
   // Input synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end
      else
      begin
         sync1_ff <= pin_in;
         sync2_ff <= sync1_ff;
      end
   end

   // Inputs read the sampled pad, outputs read back the driven level
   assign pin_view = (sync2_ff & ~dir_ff) | (val_ff & dir_ff);

   // ---------------------------------------------------------------
   // Port registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         dir_ff <= '0;
      else if (wr_dir0)
         dir_ff[31:0] <= wdata;
      else if (wr_dir1)
         dir_ff[63:32] <= wdata;
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         val_ff <= '0;
      else if (wr_val0)
         val_ff[31:0] <= wdata;
      else if (wr_val1)
         val_ff[63:32] <= wdata;
      else if (wr_pin)
         val_ff[off[7:2]] <= wdata[0];
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         pin_out_ff <= '0;
         pin_oe_ff <= '0;
      end
      else
      begin
         pin_out_ff <= val_ff;
         pin_oe_ff <= dir_ff;
      end
   end

   // ---------------------------------------------------------------
   // Pin interrupt configuration
   // ---------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         mode_ff <= '0;
         enr_ff <= '0;
         enf_ff <= '0;
      end
      else
      begin
         if (wr_mode) mode_ff <= wdata[NPINT-1:0];
         if (wr_enr) enr_ff <= wdata[NPINT-1:0];
         if (wr_enf) enf_ff <= wdata[NPINT-1:0];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < NPINT; i++)
            sel_ff[i] <= SEL_RST;
      end
      else if (wr_sel)
         sel_ff[off[4:2]] <= wdata[5:0];
   end

   always_comb
   begin
      for (int i = 0; i < NPINT; i++)
         src[i] = sync2_ff[sel_ff[i]];
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         src_ff <= '0;
         src_prev_ff <= '0;
      end
      else
      begin
         src_ff <= src;
         src_prev_ff <= src_ff;
      end
   end

   // ---------------------------------------------------------------
   // Edge flags: a new edge wins over a clear in the same cycle
   // ---------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         rise_ff <= '0;
      else
         rise_ff <= (src_ff & ~src_prev_ff) | (rise_ff & ~rise_clr);
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         fall_ff <= '0;
      else
         fall_ff <= (~src_ff & src_prev_ff) | (fall_ff & ~fall_clr);
   end

   // Mode 1 is level: enf then picks the active level, high when set
   always_comb
   begin
      for (int i = 0; i < NPINT; i++)
      begin
         if (mode_ff[i])
            irq_nxt[i] = enr_ff[i] && (src_ff[i] == enf_ff[i]);
         else
            irq_nxt[i] = (enr_ff[i] && rise_ff[i]) || (enf_ff[i] && fall_ff[i]);
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         pin_irq_ff <= '0;
      else
         pin_irq_ff <= irq_nxt;
   end

   // ---------------------------------------------------------------
   // Group blocks
   // ---------------------------------------------------------------
   gpiopg_grp u_grp0 (
      .mclk(mclk),
      .rst_n(rst_n),
      .pins(sync2_ff),
      .sel(sel_g0),
      .wr(wr_en),
      .addr(off),
      .wdata(wdata),
      .sleeping(sleeping),
      .rdata(g0_rdata),
      .irq_ff(group_irq_ff[0]),
      .wake_ff(group_wake_ff[0])
   );

   gpiopg_grp u_grp1 (
      .mclk(mclk),
      .rst_n(rst_n),
      .pins(sync2_ff),
      .sel(sel_g1),
      .wr(wr_en),
      .addr(off),
      .wdata(wdata),
      .sleeping(sleeping),
      .rdata(g1_rdata),
      .irq_ff(group_irq_ff[1]),
      .wake_ff(group_wake_ff[1])
   );

   // ---------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------
   always_comb
   begin
      nxt_rdata = RSV_READ;
      if (sel_g0)
         nxt_rdata = g0_rdata;
      else if (sel_g1)
         nxt_rdata = g1_rdata;
      else if (sel_pint)
      begin
         if (off == PINT_MODE) nxt_rdata = {24'h0, mode_ff};
         else if (off == PINT_ENR) nxt_rdata = {24'h0, enr_ff};
         else if (off == PINT_ENF) nxt_rdata = {24'h0, enf_ff};
         else if (off == PINT_RISE) nxt_rdata = {24'h0, rise_ff};
         else if (off == PINT_FALL) nxt_rdata = {24'h0, fall_ff};
         else if (off == PINT_STAT) nxt_rdata = {24'h0, pin_irq_ff};
         else if (sel_win(off)) nxt_rdata = {26'h0, sel_ff[off[4:2]]};
      end
      else if (sel_port)
      begin
         if (off == PORT_DIR0) nxt_rdata = dir_ff[31:0];
         else if (off == PORT_DIR1) nxt_rdata = dir_ff[63:32];
         else if (off == PORT_VAL0) nxt_rdata = pin_view[31:0];
         else if (off == PORT_VAL1) nxt_rdata = pin_view[63:32];
         else if (pin_win(off))
            nxt_rdata = {31'h0, pin_view[off[7:2]]};
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         rdata_ff <= RST_ZERO;
      else if (rd_en)
         rdata_ff <= nxt_rdata;
      else
         rdata_ff <= RST_ZERO;
   end
endmodule // gpiopg_top

// ===== gpiopg_props.sv
// Checker: port-level assertions for the GPIO unit
`timescale 1ns/1ps
module gpiopg_props
   import gpiopg_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [31:0] rdata_ff,
   input wire logic [NPIN-1:0] pin_in,
   input wire logic [NPIN-1:0] pin_out_ff,
   input wire logic [NPIN-1:0] pin_oe_ff,
   input wire logic sleeping,
   input wire logic [NPINT-1:0] pin_irq_ff,
   input wire logic [1:0] group_irq_ff,
   input wire logic [1:0] group_wake_ff
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic [31:0] blk;
   logic unmapped;
   assign blk = addr & BLK_MASK;
   assign unmapped = blk != PINT_BASE && blk != GRP0_BASE && blk != GRP1_BASE && blk != PORT_BASE;
   // A status clear lands one or two edges after the write
   sequence s_wr_recent;
      $past(wr_en) || $past(wr_en, 2);
   endsequence
   sequence s_rd(logic [31:0] a);
      rd_en && addr == a;
   endsequence
   rd_idle_zero_a: assert property (!$past(rd_en) |-> rdata_ff == 32'h0)
      else $error("read data not zero outside a read");
   unmapped_rd_a: assert property (rd_en && unmapped |=> rdata_ff == RSV_READ)
      else $error("unmapped read not zero");
   stat_read_a: assert property (s_rd(PINT_BASE | 32'(PINT_STAT)) |=>
      rdata_ff == {24'h0, $past(pin_irq_ff)}) else $error("pin status read wrong");
   dir_read_a: assert property (s_rd(PORT_BASE) |=> rdata_ff == pin_oe_ff[31:0])
      else $error("direction read wrong");
   pin_hold_a: assert property (!$past(wr_en, 2) |-> $stable(pin_oe_ff) && $stable(pin_out_ff))
      else $error("pin drive changed without write");
   wake_sleep_a: assert property ((group_wake_ff & ~{2{$past(sleeping)}}) == 2'b00)
      else $error("wake outside power saving");
   wake_first_a: assert property ($rose(group_irq_ff[0]) && $past(sleeping, 2) |->
      $past(group_wake_ff[0])) else $error("request before wake");
   grp_clear_a: assert property ($fell(group_irq_ff[0]) |-> s_wr_recent)
      else $error("group request fell without write");
   rst_quiet_a: assert property ($rose(rst_n) |-> pin_oe_ff == 64'h0 && pin_irq_ff == 8'h0
      && group_irq_ff == 2'h0 && group_wake_ff == 2'h0) else $error("outputs not quiet");
endmodule // gpiopg_props
bind gpiopg_top gpiopg_props u_props (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
   .wr_en(wr_en), .rd_en(rd_en), .rdata_ff(rdata_ff), .pin_in(pin_in), .pin_out_ff(pin_out_ff),
   .pin_oe_ff(pin_oe_ff), .sleeping(sleeping), .pin_irq_ff(pin_irq_ff),
   .group_irq_ff(group_irq_ff), .group_wake_ff(group_wake_ff));

// ===== gpiopg_pads.sv
// Partner: pad model joining driven outputs with external levels
`timescale 1ns/1ps
module gpiopg_pads
   import gpiopg_pkg::*;
(
   input wire logic [NPIN-1:0] ext_lvl,
   input wire logic [NPIN-1:0] drv,
   input wire logic [NPIN-1:0] oe,
   output logic [NPIN-1:0] pin_in
);
   // Driven pads show the driven level, the rest the outside source
   assign pin_in = (oe & drv) | (~oe & ext_lvl);
endmodule // gpiopg_pads

// ===== test_gpio_port_with_pin_and_group_irq.sv
// Testbench: register-level scenarios for the GPIO unit
`timescale 1ns/1ps
module test_gpio_port_with_pin_and_group_irq
   import gpiopg_pkg::*;
;
   logic mclk, rst_n, wr_en, rd_en, sleeping;
   logic [31:0] addr, wdata, rdata_ff, rv;
   logic [63:0] pad_lvl, pin_in, pin_out_ff, pin_oe_ff;
   logic [7:0] pin_irq_ff;
   logic [1:0] group_irq_ff, group_wake_ff;
   logic [3:0] etab [3] = '{4'b1010, 4'b0101, 4'b1111};
   int err_count, tests_run;
   gpiopg_top DUT (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata_ff(rdata_ff), .pin_in(pin_in), .pin_out_ff(pin_out_ff),
      .pin_oe_ff(pin_oe_ff), .sleeping(sleeping), .pin_irq_ff(pin_irq_ff),
      .group_irq_ff(group_irq_ff), .group_wake_ff(group_wake_ff));
   gpiopg_pads u_pads (.ext_lvl(pad_lvl), .drv(pin_out_ff), .oe(pin_oe_ff), .pin_in(pin_in));
   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   function automatic logic [31:0] f(input logic [31:0] b, input logic [11:0] o);
      return b | {20'h0, o};
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // Settles past the write edge so callers may compare at once
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge mclk);
      wr_en <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1 d = rdata_ff;
   endtask
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
         err_count++;
      end
   endtask
   task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] e);
      rd(a, rv);
      chk(nm, rv, e);
   endtask
   // Two edge synchronisers plus detection fit well inside eight cycles
   task automatic setp(input int p, input logic v);
      @(posedge mclk);
      pad_lvl[p] <= v;
      cyc(8);
   endtask
   task automatic clr();
      wr(f(PINT_BASE, PINT_RISE), 32'hff);
      wr(f(PINT_BASE, PINT_FALL), 32'hff);
      cyc(3);
   endtask
   task automatic close_out();
      if (err_count == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial
   begin
      #(25 * 20000);
      err_count++;
      close_out();
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial
   begin
      rst_n = 1'b0;
      addr = 32'h0;
      wdata = 32'h0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      sleeping = 1'b0;
      pad_lvl = 64'h3c3c0f0f_5a5a9696;
      err_count = 0;
      tests_run = 0;
      cyc(12);
      rst_n <= 1'b1;
      #1;
      chk("oe", pin_oe_ff, 64'h0);
      chk("irq", {pin_irq_ff, group_irq_ff, group_wake_ff}, 64'h0);
      rc("dir1", f(PORT_BASE, PORT_DIR1), 32'h0);
      rc("enr", f(PINT_BASE, PINT_ENR), 32'h0);
      rc("ena0", f(GRP0_BASE, GRP_ENA0), 32'h0);
      rc("val0", f(PORT_BASE, PORT_VAL0), 32'h5a5a9696);
      wr(f(PORT_BASE, PORT_DIR0), 32'h0000ffff);
      wr(f(PORT_BASE, PORT_DIR1), 32'h00000100);
      wr(f(PORT_BASE, PORT_VAL0), 32'h1234abcd);
      // Pin drivers follow the registers one edge later
      cyc(1);
      #1;
      chk("oe", pin_oe_ff, 64'h00000100_0000ffff);
      chk("out", pin_out_ff[15:0], 64'habcd);
      rc("val0", f(PORT_BASE, PORT_VAL0), 32'h5a5aabcd);
      wr(f(PORT_BASE, PORT_PIN0 + 12'd160), 32'h1);
      cyc(1);
      #1;
      chk("pin40", {pin_out_ff[40], pin_out_ff[15:0]}, 64'h1abcd);
      rc("pin33", f(PORT_BASE, PORT_PIN0 + 12'd132), 32'h1);
      rc("pin36", f(PORT_BASE, PORT_PIN0 + 12'd144), 32'h0);
      wr(32'h60000000, 32'hffffffff);
      rc("unmap", 32'h60000000, 32'h0);
      rc("rsvd", f(PORT_BASE, 12'h300), 32'h0);
      rc("dir0", f(PORT_BASE, PORT_DIR0), 32'h0000ffff);
      wr(f(GRP0_BASE, GRP_CTRL), 32'hfffffff8);
      rc("ctrl", f(GRP0_BASE, GRP_CTRL), 32'h0);
      wr(f(PORT_BASE, PORT_DIR0), 32'h0);
      wr(f(PORT_BASE, PORT_DIR1), 32'h0);
      @(posedge mclk);
      pad_lvl <= 64'h0;
      for (int i = 0; i < 8; i++)
         wr(f(PINT_BASE, PINT_SEL0 + 12'(4 * i)), 32'(7 * i + 5));
      wr(f(PINT_BASE, PINT_ENR), 32'hff);
      clr();
      for (int i = 0; i < 8; i++)
      begin
         setp(7 * i + 5, 1'b1);
         chk("src", pin_irq_ff, 64'h1 << i);
         rc("stat", f(PINT_BASE, PINT_STAT), 32'h1 << i);
         setp(7 * i + 5, 1'b0);
         clr();
      end
      for (int i = 0; i < 3; i++)
      begin
         wr(f(PINT_BASE, PINT_ENR), {31'h0, etab[i][3]});
         wr(f(PINT_BASE, PINT_ENF), {31'h0, etab[i][2]});
         clr();
         setp(5, 1'b1);
         chk("rise", pin_irq_ff[0], etab[i][1]);
         clr();
         chk("once", pin_irq_ff[0], 1'b0);
         setp(5, 1'b0);
         chk("fall", pin_irq_ff[0], etab[i][0]);
         clr();
      end
      wr(f(PINT_BASE, PINT_MODE), 32'h1);
      wr(f(PINT_BASE, PINT_ENR), 32'h1);
      wr(f(PINT_BASE, PINT_ENF), 32'h0);
      cyc(8);
      chk("lvl_lo", pin_irq_ff[0], 1'b1);
      setp(5, 1'b1);
      chk("lvl_lo", pin_irq_ff[0], 1'b0);
      wr(f(PINT_BASE, PINT_ENF), 32'h1);
      cyc(6);
      chk("lvl_hi", pin_irq_ff[0], 1'b1);
      wr(f(PINT_BASE, PINT_ENR), 32'h0);
      @(posedge mclk);
      pad_lvl <= 64'h8_00000000;
      wr(f(GRP0_BASE, GRP_ENA0), 32'h4);
      wr(f(GRP0_BASE, GRP_ENA1), 32'h8);
      wr(f(GRP0_BASE, GRP_POL0), 32'h4);
      wr(f(GRP0_BASE, GRP_CTRL), 32'h1);
      cyc(4);
      chk("grp", group_irq_ff, 2'b00);
      setp(2, 1'b1);
      chk("grp_or", group_irq_ff, 2'b01);
      wr(f(GRP0_BASE, GRP_CTRL), 32'h1);
      cyc(4);
      chk("grp_lvl", group_irq_ff, 2'b01);
      setp(2, 1'b0);
      wr(f(GRP0_BASE, GRP_CTRL), 32'h1);
      cyc(4);
      chk("grp_clr", group_irq_ff, 2'b00);
      setp(35, 1'b0);
      chk("grp_pol", group_irq_ff, 2'b01);
      // Switch mode first: a clear beside a live match loses to the set
      wr(f(GRP0_BASE, GRP_CTRL), 32'h2);
      wr(f(GRP0_BASE, GRP_CTRL), 32'h3);
      cyc(4);
      chk("grp_and", group_irq_ff, 2'b00);
      @(posedge mclk);
      sleeping <= 1'b1;
      setp(2, 1'b1);
      chk("wake", {group_wake_ff, group_irq_ff}, 4'b0101);
      @(posedge mclk);
      sleeping <= 1'b0;
      wr(f(GRP0_BASE, GRP_CTRL), 32'h6);
      wr(f(GRP0_BASE, GRP_CTRL), 32'h7);
      cyc(4);
      chk("grp_edge", group_irq_ff, 2'b00);
      setp(2, 1'b0);
      setp(2, 1'b1);
      chk("grp_edge", group_irq_ff, 2'b01);
      wr(f(GRP1_BASE, GRP_ENA1), 32'h10000000);
      wr(f(GRP1_BASE, GRP_POL1), 32'h10000000);
      wr(f(GRP1_BASE, GRP_CTRL), 32'h1);
      setp(60, 1'b1);
      chk("grp1", group_irq_ff, 2'b11);
      close_out();
   end
endmodule // test_gpio_port_with_pin_and_group_irq
